// *** pkg/sacbp_pkg.sv ***
// Shared constants for the converter bus port and its host end
package sacbp_pkg;
  localparam int          RES_W          = 12;
  localparam int          BYTE_W         = 8;
  localparam int          CLK_PERIOD_NS  = 100;
  // Conversion timing of the device model
  localparam int          CONV_TIME_NS   = 4000;
  localparam int          CONV_CYC       = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int          HOLD_TIME_NS   = 1000;
  localparam int          HOLD_CYC       = HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int          ACQ_MIN_NS     = 1000;
  // Host timing figures, least times rounded up
  localparam int          START_REPEAT_NS = 5000;
  localparam int          START_REPEAT_CYC = (START_REPEAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          START_PULSE_NS = 200;
  localparam int          START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETUP_NS       = 100;
  localparam int          SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RECOVERY_NS    = 100;
  localparam int          RECOVERY_CYC   = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 8;
  // Result pin positions used as inputs in 8-bit format
  localparam int          PIN_JUSTIFY    = 1;
  localparam int          PIN_BYTE_SEL   = 0;
  localparam logic [3:0]  PAD_ZERO       = 4'h0;
  localparam logic [RES_W-1:0] RES_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
endpackage

// *** pkg/sacbp_if.sv ***
// Pin-level link between the converter port and its host
`timescale 1ns/1ps
`default_nettype none
interface sacbp_if;
  import sacbp_pkg::*;
  logic             start_convert_n;
  logic             chip_select_n;
  logic             output_enable_n;
  logic             done_flag_enable_n;
  logic             gated_start;
  logic             format_12bit;
  logic [RES_W-1:0] dev_data_o;
  logic [RES_W-1:0] dev_data_oe;
  logic [1:0]       host_fmt_o;
  logic             host_fmt_oe;
  logic             done_o;
  logic             done_oe;
  modport device (
    input  start_convert_n, chip_select_n, output_enable_n, done_flag_enable_n,
    input  gated_start, format_12bit, host_fmt_o, host_fmt_oe,
    output dev_data_o, dev_data_oe, done_o, done_oe
  );
  modport host (
    output start_convert_n, chip_select_n, output_enable_n, done_flag_enable_n,
    output gated_start, format_12bit, host_fmt_o, host_fmt_oe,
    input  dev_data_o, dev_data_oe, done_o, done_oe
  );
endinterface
`default_nettype wire

// *** core/sacbp_device.sv ***
// Converter end: start decode, sample-hold sequencing, status and result pins
// Behaviour
// - Gated mode: start needs select and start low
// - Free mode: start falling edge alone starts
// - Idle: done high, sample-hold tracking
// - Start: hold mode, done goes low
// - Mid conversion track again; done rises at end
// - Track resumes over 1 us before next start
// - Host may switch channel when done falls
// - Unipolar: straight binary result
// - Bipolar: twos complement result
// - Result pins driven only when select and enable low
// - 8-bit format: two low pins are inputs
// - 8-bit: upper eight pins, high byte first
// - Byte select low high byte, high low byte
// - Justify right pads top, left pads bottom
// - 12-bit format: all bits in one read
// - Host reads after done rises, enable after select
// - Host waits recovery before next start
// - Host spaces starts at least 5 us
// - Host never holds start low continuously
// - Start is a falling edge held low
// - Free mode: done is open drain, enabled
// - Gated mode: done driven when select, enable low
// - Free mode: done pulls low only converting
// - Format pin high 12-bit, low 8-bit
`timescale 1ns/1ps
`default_nettype none
module sacbp_device
  import sacbp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  sacbp_if.device               link,
  input  wire logic [RES_W-1:0] i_sample,
  input  wire logic             i_bipolar,
  output logic                  o_track,
  output logic                  o_converting
);
  // Conversion timeline, in clocks after the start edge is taken:
  //   edge 0     sample latched, sample-hold to hold, done low
  //   HOLD_CYC   sample-hold back to track for the next sample
  //   CONV_CYC   result register loaded, done high again
  // Tracking covers the rest of the conversion and all idle time,
  // so acquisition runs well over a microsecond before the next start.
  // Starts seen while converting are ignored, not queued.
  // The start detector resets to the asserted level: a start pin
  // already low at reset release does not launch a conversion.
  // The sample input is latched only at the start edge, so the host
  // may switch channel as soon as done falls.
  // Result pins show the last finished result, never a partial one.
  // The format pins are read live; the host steers the byte order.
  // Done is never driven high in free mode; a pull-up provides it.
  // Counts assume the 100 ns clock; change the package figures together.

  // Idle, hold phase, then track phase until the result is ready
  typedef enum logic [1:0] {SACBP_IDLE, SACBP_HOLD, SACBP_TRACK} sacbp_state_t;
  // Everything registered, updated as one word
  typedef struct packed {
    sacbp_state_t     state;
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] result;
    logic             start_prev;
  } sacbp_dev_t;

  // Registered state and its next value
  sacbp_dev_t s_reg;
  sacbp_dev_t s_next;
  // Combinational helpers
  logic       start_level;
  logic       read_en;
  logic       justify_right;
  logic       byte_low;
  logic [RES_W-1:0] coded;
  logic [BYTE_W-1:0] byte_out;
  logic [3:0] lead;
  // Status decodes
  logic       in_idle;
  logic       in_hold;
  logic       done_level;

  // Start qualifier: gated mode also needs chip select
  always_comb begin
    if (link.gated_start) begin
      // Both strobes must be low together
      start_level = !link.start_convert_n && !link.chip_select_n;
    end else begin
      // Select is ignored
      start_level = !link.start_convert_n;
    end
  end

  // Output coding: bipolar flips the top bit of the offset-binary sample
  assign coded = i_bipolar ? {~i_sample[RES_W-1], i_sample[RES_W-2:0]}
                           : i_sample;

  // Conversion sequencer
  always_comb begin
    // Default: keep every field, follow the start level
    s_next = s_reg;
    s_next.start_prev = start_level;
    case (s_reg.state)
      // Idle: wait for a fresh start edge
      SACBP_IDLE: begin
        if (start_level && !s_reg.start_prev) begin
          s_next.state = SACBP_HOLD;
          // Latch the sample on the start edge
          s_next.held  = coded;
          s_next.cnt   = CNT_ZERO;
        end
      end
      // Hold phase: sample frozen while the first steps convert
      SACBP_HOLD: begin
        s_next.cnt = s_reg.cnt + 8'd1;
        // Leave hold at the end of the hold window
        if (s_reg.cnt == 8'(HOLD_CYC - 1)) begin
          s_next.state = SACBP_TRACK;
        end
      end
      // Track phase: next sample acquiring while the result finishes
      SACBP_TRACK: begin
        s_next.cnt = s_reg.cnt + 8'd1;
        // Result handed over on the last track cycle
        if (s_reg.cnt == 8'(CONV_CYC - 1)) begin
          s_next.state  = SACBP_IDLE;
          s_next.result = s_reg.held;
        end
      end
      // Unused encoding: back to idle
      default: s_next.state = SACBP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // Idle and tracking; start detector primed as if start were asserted
      s_reg.state      <= SACBP_IDLE;
      s_reg.cnt        <= CNT_ZERO;
      s_reg.held       <= RES_RESET;
      s_reg.result     <= RES_RESET;
      s_reg.start_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Status decodes: done is simply the inverse of converting
  assign in_idle      = (s_reg.state == SACBP_IDLE);
  assign in_hold      = (s_reg.state == SACBP_HOLD);
  assign done_level   = in_idle;
  assign o_converting = !in_idle;
  assign o_track      = !in_hold;

  // Read strobe and the two format inputs sampled from pins 1:0
  assign read_en       = !link.chip_select_n && !link.output_enable_n;
  assign justify_right = link.host_fmt_o[PIN_JUSTIFY];
  assign byte_low      = link.host_fmt_o[PIN_BYTE_SEL];
  assign lead          = i_bipolar ? {4{s_reg.result[RES_W-1]}} : PAD_ZERO;

  // Byte steering for the 8-bit format, right or left justified
  always_comb begin
    case ({justify_right, byte_low})
      2'h2: begin
        byte_out = {lead, s_reg.result[11:8]};
      end
      2'h3: begin
        byte_out = s_reg.result[7:0];
      end
      2'h0: begin
        byte_out = s_reg.result[11:4];
      end
      default: begin
        byte_out = {s_reg.result[3:0], PAD_ZERO};
      end
    endcase
  end

  // Result pins and their enables; pins 1:0 stay inputs in 8-bit format
  always_comb begin
    if (link.format_12bit) begin
      // Whole word in one read
      link.dev_data_o  = s_reg.result;
      link.dev_data_oe = {RES_W{read_en}};
    end else begin
      // One byte on the upper eight pins, low four released
      link.dev_data_o  = {byte_out, PAD_ZERO};
      link.dev_data_oe = {{BYTE_W{read_en}}, PAD_ZERO};
    end
  end

  // Done flag: three-state in gated mode, open drain in free mode
  always_comb begin
    // Released unless a branch below drives it
    link.done_o  = 1'b0;
    link.done_oe = 1'b0;
    if (link.gated_start) begin
      // Driven both ways, only while selected and enabled
      link.done_oe = !link.chip_select_n && !link.done_flag_enable_n;
      link.done_o  = done_level;
    end else begin
      // Only ever pulls low; the pull-up supplies the high level
      link.done_oe = !link.done_flag_enable_n && o_converting;
      link.done_o  = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** core/sacbp_host.sv ***
// Host end: issues starts, waits for done, reads the result
`timescale 1ns/1ps
`default_nettype none
module sacbp_host
  import sacbp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  sacbp_if.host                 link,
  input  wire logic             i_go,
  input  wire logic             i_gated,
  input  wire logic             i_fmt12,
  input  wire logic             i_justify_right,
  output logic                  o_busy,
  output logic                  o_valid,
  output logic [RES_W-1:0]      o_result
);
  typedef enum logic [2:0] {SACBPH_IDLE, SACBPH_SEL, SACBPH_START, SACBPH_WAIT,
                            SACBPH_RD_HI, SACBPH_RD_LO, SACBPH_REC} sacbp_hstate_t;
  typedef struct packed {
    sacbp_hstate_t    state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] space;
    logic [RES_W-1:0] result;
    logic             valid;
  } sacbp_host_t;

  sacbp_host_t h_reg;
  sacbp_host_t h_next;
  logic        done_seen;

  // Done pin level with pull-up resolved here from the enable
  assign done_seen = link.done_oe ? link.done_o : 1'b1;

  // Host sequencer
  always_comb begin
    h_next = h_reg;
    h_next.valid = 1'b0;
    if (h_reg.space != CNT_ZERO) begin
      h_next.space = h_reg.space - 8'd1;
    end
    case (h_reg.state)
      SACBPH_IDLE: begin
        if (i_go && h_reg.space == CNT_ZERO) begin
          h_next.state = SACBPH_SEL;
          h_next.cnt   = CNT_ZERO;
        end
      end
      SACBPH_SEL: begin
        h_next.state = SACBPH_START;
        h_next.cnt   = CNT_ZERO;
        h_next.space = 8'(START_REPEAT_CYC);
      end
      SACBPH_START: begin
        h_next.cnt = h_reg.cnt + 8'd1;
        if (h_reg.cnt == 8'(START_PULSE_CYC - 1)) begin
          h_next.state = SACBPH_WAIT;
          h_next.cnt   = CNT_ZERO;
        end
      end
      SACBPH_WAIT: begin
        h_next.cnt = h_reg.cnt + 8'd1;
        if (h_reg.cnt > 8'd1 && done_seen) begin
          h_next.state   = SACBPH_RD_HI;
          h_next.cnt     = CNT_ZERO;
        end
      end
      SACBPH_RD_HI: begin
        h_next.cnt = h_reg.cnt + 8'd1;
        if (h_reg.cnt == 8'(SETUP_CYC)) begin
          if (i_fmt12) begin
            h_next.result = link.dev_data_o;
            h_next.state  = SACBPH_REC;
            h_next.valid  = 1'b1;
          end else begin
            h_next.result[11:4] = link.dev_data_o[11:4];
            h_next.state = SACBPH_RD_LO;
          end
          h_next.cnt = CNT_ZERO;
        end
      end
      SACBPH_RD_LO: begin
        h_next.cnt = h_reg.cnt + 8'd1;
        if (h_reg.cnt == 8'(SETUP_CYC)) begin
          // Reassemble whichever justification was requested
          if (i_justify_right) begin
            h_next.result = {h_reg.result[7:4], link.dev_data_o[11:4]};
          end else begin
            h_next.result = {h_reg.result[11:4], link.dev_data_o[11:8]};
          end
          h_next.valid = 1'b1;
          h_next.state = SACBPH_REC;
          h_next.cnt   = CNT_ZERO;
        end
      end
      SACBPH_REC: begin
        h_next.cnt = h_reg.cnt + 8'd1;
        if (h_reg.cnt == 8'(RECOVERY_CYC - 1)) begin
          h_next.state = SACBPH_IDLE;
        end
      end
      default: h_next.state = SACBPH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      h_reg <= '{state: SACBPH_IDLE, cnt: CNT_ZERO, space: CNT_ZERO,
                 result: RES_RESET, valid: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  // Pin drive; select also stays low while polling done, which gated mode needs
  assign link.gated_start        = i_gated;
  assign link.format_12bit       = i_fmt12;
  assign link.chip_select_n      = !(h_reg.state == SACBPH_SEL || h_reg.state == SACBPH_START
                                     || h_reg.state == SACBPH_WAIT
                                     || h_reg.state == SACBPH_RD_HI
                                     || h_reg.state == SACBPH_RD_LO);
  assign link.start_convert_n    = (h_reg.state != SACBPH_START);
  assign link.output_enable_n    = !((h_reg.state == SACBPH_RD_HI || h_reg.state == SACBPH_RD_LO)
                                     && h_reg.cnt != CNT_ZERO);
  assign link.done_flag_enable_n = (h_reg.state != SACBPH_WAIT);
  assign link.host_fmt_o         = {i_justify_right, h_reg.state == SACBPH_RD_LO};
  assign link.host_fmt_oe        = !i_fmt12;
  assign o_busy                  = (h_reg.state != SACBPH_IDLE);
  assign o_valid                 = h_reg.valid;
  assign o_result                = h_reg.result;
endmodule
`default_nettype wire

// *** tb/sacbp_assertions.sv ***
// Pin-level checks on the link between converter and host ends
`timescale 1ns/1ps
`default_nettype none
module sacbp_assertions
  import sacbp_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  input wire logic             start_convert_n,
  input wire logic             chip_select_n,
  input wire logic             output_enable_n,
  input wire logic             done_flag_enable_n,
  input wire logic             gated_start,
  input wire logic             format_12bit,
  input wire logic [RES_W-1:0] dev_data_oe,
  input wire logic             host_fmt_oe,
  input wire logic             done_o,
  input wire logic             done_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] gap;
  logic       sc_q;
  // Cycles since the last start edge, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gap <= 8'hFF;
    end else if (sc_q && !start_convert_n) begin
      gap <= 8'h00;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  // Previous start level, for edge detection
  always_ff @(posedge i_clk) begin
    sc_q <= i_rst_n ? start_convert_n : 1'b1;
  end
  // Result pins, format pins, done flag and start timing
  a_data_float: assert property ((chip_select_n || output_enable_n) |-> dev_data_oe == '0)
    else $error("result pins driven while not selected");
  a_word_drive: assert property (format_12bit && !chip_select_n && !output_enable_n
    |-> dev_data_oe == 12'hFFF) else $error("word read not fully driven");
  a_fmt_pins_in: assert property (!format_12bit |-> dev_data_oe[1:0] == 2'h0)
    else $error("format pins driven by converter");
  a_fmt_host_off: assert property (format_12bit |-> !host_fmt_oe)
    else $error("host drives format pins in word mode");
  a_byte_drive: assert property (!format_12bit && !chip_select_n && !output_enable_n
    |-> dev_data_oe[11:4] == 8'hFF) else $error("byte lanes not driven");
  a_done_sync_off: assert property (gated_start && (chip_select_n || done_flag_enable_n)
    |-> !done_oe) else $error("done driven without select");
  a_done_sync_on: assert property (gated_start && !chip_select_n && !done_flag_enable_n
    |-> done_oe) else $error("done not driven when enabled");
  a_done_open_drain: assert property (!gated_start && done_oe |-> !done_o)
    else $error("done driven high in free mode");
  a_done_free_off: assert property (!gated_start && done_flag_enable_n |-> !done_oe)
    else $error("done pulled while disabled");
  a_start_width: assert property ($fell(start_convert_n) |=> !start_convert_n)
    else $error("start pulse too short");
  a_start_repeat: assert property ((sc_q && !start_convert_n) |-> gap >= 8'h31)
    else $error("starts closer than repeat interval");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench joining the host and converter ends
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sacbp_pkg::*;
  logic             i_clk, i_rst_n, i_go, i_gated, i_fmt12, i_justify_right, i_bipolar;
  logic             o_track, o_converting, o_busy, o_valid, held;
  logic [RES_W-1:0] i_sample, o_result, code;
  logic [RES_W-1:0] samples [5] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF, 12'hA5C};
  int               errors = 0;
  int               compares = 0;
  int               cycles = 0;
  sacbp_if          link ();
  sacbp_device sacbp_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link),
    .i_sample(i_sample), .i_bipolar(i_bipolar), .o_track(o_track), .o_converting(o_converting));
  sacbp_host sacbp_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_go(i_go),
    .i_gated(i_gated), .i_fmt12(i_fmt12), .i_justify_right(i_justify_right),
    .o_busy(o_busy), .o_valid(o_valid), .o_result(o_result));
  sacbp_assertions sacbp_assertions_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .start_convert_n(link.start_convert_n), .chip_select_n(link.chip_select_n),
    .output_enable_n(link.output_enable_n), .done_flag_enable_n(link.done_flag_enable_n),
    .gated_start(link.gated_start), .format_12bit(link.format_12bit),
    .dev_data_oe(link.dev_data_oe), .host_fmt_oe(link.host_fmt_oe),
    .done_o(link.done_o), .done_oe(link.done_oe));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [RES_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One conversion in the given mode, watching pins and sample-hold on the way
  task automatic convert(input logic [3:0] mode, input logic [RES_W-1:0] smp);
    int               n;
    int               trk;
    logic [BYTE_W-1:0] hi, lo;
    n = 0;
    trk = 0;
    held = 1'b0;
    code = mode[3] ? smp ^ 12'h800 : smp;
    hi = mode[2] ? {(mode[3] ? {4{code[11]}} : 4'h0), code[11:8]} : code[11:4];
    lo = mode[2] ? code[7:0] : {code[3:0], 4'h0};
    @(posedge i_clk);
    {i_bipolar, i_justify_right, i_fmt12, i_gated} <= {mode[3], mode[2], ~mode[1], mode[0]};
    i_sample <= smp;
    @(posedge i_clk);
    i_go <= 1'b1;
    @(negedge i_clk);
    check("track idle", {11'h0, o_track}, 12'h001);
    check("busy idle", {11'h0, o_busy}, 12'h000);
    while (link.start_convert_n !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    i_go <= 1'b0;
    i_sample <= ~smp;
    n = 0;
    while (o_valid !== 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
      if (o_converting === 1'b1 && o_track === 1'b0) held = 1'b1;
      if (o_converting === 1'b1 && o_track === 1'b1) trk++;
      if (link.chip_select_n === 1'b0 && link.output_enable_n === 1'b0) begin
        if (!mode[1]) check("word", link.dev_data_o, code);
        else check("byte", {4'h0, link.dev_data_o[11:4]}, {4'h0, link.host_fmt_o[0] ? lo : hi});
      end
    end
    check("valid", {11'h0, o_valid}, 12'h001);
    check("result", o_result, code);
    check("hold seen", {11'h0, held}, 12'h001);
    check("track time", {11'h0, trk > ACQ_MIN_NS / CLK_PERIOD_NS}, 12'h001);
    check("track end", {11'h0, o_track}, 12'h001);
    check("busy end", {11'h0, o_busy}, 12'h001);
    check("converting end", {11'h0, o_converting}, 12'h000);
  endtask
  // Main sequence: every mix of start mode, format, justify and coding
  initial begin
    i_rst_n = 1'b0;
    i_go = 1'b0;
    i_gated = 1'b0;
    i_fmt12 = 1'b1;
    i_justify_right = 1'b0;
    i_bipolar = 1'b0;
    i_sample = 12'h000;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) begin
      convert(i[3:0], samples[i % 5]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
